// ==== common/cdm_defs.svh ====
`ifndef CDM_DEFS_SVH
`define CDM_DEFS_SVH

// register byte offsets
`define CDM_CTRL_OFS       8'h00
`define CDM_INTST_OFS      8'h04
`define CDM_INTEN_OFS      8'h08
`define CDM_LERR_OFS       8'h0c
`define CDM_TSCTRL_OFS     8'h10
`define CDM_TXREQ_OFS      8'h14

// control register fields
`define CDM_CTRL_MODE_LSB  0
`define CDM_CTRL_MODE_MSB  2
`define CDM_CTRL_AL_BIT    4
`define CDM_CTRL_VALID_BIT 8
`define CDM_CTRL_PS0_BIT   12
`define CDM_CTRL_WAKE_BIT  13

// status and enable fields
`define CDM_ST_TXC_BIT     0
`define CDM_ST_PERR_BIT    3
`define CDM_ST_ARBL_BIT    4

// time-stamp control fields
`define CDM_TS_EN_BIT      0
`define CDM_TS_SEL_BIT     1
`define CDM_TS_LOCK_BIT    2
`define CDM_TS_OUT_BIT     8

`define CDM_TXREQ_BIT      0

// mode field codes
`define CDM_MODE_INIT      3'h0
`define CDM_MODE_NORMAL    3'h1
`define CDM_MODE_ABT       3'h2
`define CDM_MODE_RXONLY    3'h3
`define CDM_MODE_SINGLE    3'h4
`define CDM_MODE_SELFTEST  3'h5

`define CDM_RECESSIVE      1'h1
`define CDM_BUF0           4'h0

`endif

// ==== common/cdm_pkg.sv ====
package cdm_pkg;

   typedef enum logic [1:0] {
      CDM_APB_IDLE,
      CDM_APB_ACCESS
   } cdm_apb_state_type;

   typedef logic [2:0] cdm_mode_type;

   typedef struct packed {
      logic tx;
      logic ack;
      logic errframe;
      logic retry_arb;
      logic retry_err;
      logic block_tx;
      logic store;
      logic drive_pin;
      logic loopback;
   } cdm_perm_type;

endpackage : cdm_pkg

// ==== src/cdm_can_diag.sv ====
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cdm_defs.svh"

// Summary of operation
// - single-shot: no automatic repeat after error abort
// - single-shot otherwise equals normal mode when retry bit is 1
// - retry bit 0: no retry at all
// - retry bit 1: retry arbitration loss only
// - single-shot clears request on success, error, and on loss with retry bit 0
// - loss and error set flags, code recorded
// - success sets flag; irq when enabled
// - retry bit ignored outside single-shot
// - self-test loops back, transmit pin recessive
// - sleep wakes on rx falling edge
// - per-mode permissions for init and normal
// - receive-only silent; single-shot no error retry
// - self-test signalling stays inside module
// - time-stamp output toggles on selected event
// - select 0 start, 1 end of frame
// - toggles only while enabled
// - lock clears enable when buffer 0 stores
// - only data frames into buffer 0 stop
// - valid flag set on good reception in any mode except init
module cdm_can_diag #(
   parameter int ADDR_W = 8,
   parameter int BUF_W  = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        bus_rx_pin,
   output var  logic        bus_tx_pin,
   input  wire logic        core_tx_bit,
   output var  logic        core_rx_bit,
   input  wire logic        core_tx_success,
   input  wire logic        core_arb_loss,
   input  wire logic        core_tx_error,
   input  wire logic [2:0]  core_error_code,
   input  wire logic        core_rx_valid,
   input  wire logic        core_sof,
   input  wire logic        core_eof,
   input  wire logic        core_data_frame,
   input  wire logic        core_store_start,
   input  wire logic [BUF_W-1:0] core_store_buf,
   input  wire logic        core_store_remote,
   output var  logic        tx_request_bit,
   output var  logic        tx_enable,
   output var  logic        ack_enable,
   output var  logic        errframe_enable,
   output var  logic        retry_arb_en,
   output var  logic        retry_err_en,
   output var  logic        block_tx_en,
   output var  logic        store_enable,
   output var  logic        tx_complete_irq,
   output var  logic        timestamp_toggle_out
);

   if (ADDR_W < 5 || ADDR_W > 32 || BUF_W < 1 || BUF_W > 8) begin : g_param_check
      $error("cdm_can_diag: unsupported ADDR_W or BUF_W");
   end

   // mode permission decode, used for outputs and for dropping the request after an abort
   function automatic cdm_pkg::cdm_perm_type perm_of(input cdm_pkg::cdm_mode_type m,
                                                     input logic al);
      cdm_pkg::cdm_perm_type p;
      p = '0;
      if (m == `CDM_MODE_NORMAL || m == `CDM_MODE_ABT || m == `CDM_MODE_SELFTEST) begin
         p.tx        = 1'b1;
         p.ack       = 1'b1;
         p.errframe  = 1'b1;
         p.retry_arb = 1'b1;
         p.retry_err = 1'b1;
         p.store     = 1'b1;
      end else if (m == `CDM_MODE_SINGLE) begin
         p.tx        = 1'b1;
         p.ack       = 1'b1;
         p.errframe  = 1'b1;
         p.retry_arb = al;
         p.retry_err = 1'b0;
         p.store     = 1'b1;
      end else if (m == `CDM_MODE_RXONLY) begin
         p.store     = 1'b1;
      end
      p.block_tx  = (m == `CDM_MODE_ABT);
      p.drive_pin = p.tx && (m != `CDM_MODE_SELFTEST);
      p.loopback  = (m == `CDM_MODE_SELFTEST);
      return p;
   endfunction : perm_of

   // apb slave state
   cdm_pkg::cdm_apb_state_type apb_state_reg, apb_state_next;
   logic [31:0] prdata_next;
   logic        pready_next, pslverr_next;

   // software visible state
   cdm_pkg::cdm_mode_type mode_reg, mode_next;
   logic        al_reg, al_next;
   logic        valid_reg, valid_next;
   logic        ps0_reg, ps0_next;
   logic        wake_reg, wake_next;
   logic [4:0]  intst_reg, intst_next;
   logic        txc_en_reg, txc_en_next;
   logic [2:0]  lec_reg, lec_next;
   logic        ts_en_reg, ts_en_next;
   logic        ts_sel_reg, ts_sel_next;
   logic        ts_lock_reg, ts_lock_next;
   logic        ts_out_next;
   logic        txreq_next;
   logic        irq_next;
   cdm_pkg::cdm_perm_type perm_reg, perm_next, cur_perm;

   // pin path
   logic [2:0]  rx_sync_reg;
   logic        tx_pin_next, core_rx_next;

   logic wr_access, rd_setup, hit;
   logic [ADDR_W-1:0] ofs;
   logic sw_txreq_set, ts_event, lock_stop;

   assign ofs       = paddr;
   assign wr_access = psel && penable && pready && pwrite;
   assign rd_setup  = psel && !penable;
   assign cur_perm  = perm_of(mode_reg, al_reg);

   // apb: setup cycle prepares the answer, access cycle completes with pready high
   always_comb begin
      apb_state_next = apb_state_reg;
      pready_next    = 1'b0;
      pslverr_next   = 1'b0;
      prdata_next    = 32'h0000_0000;
      hit            = 1'b1;
      case (apb_state_reg)
         cdm_pkg::CDM_APB_IDLE: begin
            if (rd_setup) begin
               apb_state_next = cdm_pkg::CDM_APB_ACCESS;
               pready_next    = 1'b1;
               if (ofs == ADDR_W'(`CDM_CTRL_OFS)) begin
                  prdata_next[`CDM_CTRL_MODE_MSB:`CDM_CTRL_MODE_LSB] = mode_reg;
                  prdata_next[`CDM_CTRL_AL_BIT]    = al_reg;
                  prdata_next[`CDM_CTRL_VALID_BIT] = valid_reg;
                  prdata_next[`CDM_CTRL_PS0_BIT]   = ps0_reg;
                  prdata_next[`CDM_CTRL_WAKE_BIT]  = wake_reg;
               end else if (ofs == ADDR_W'(`CDM_INTST_OFS)) begin
                  prdata_next[4:0] = intst_reg;
               end else if (ofs == ADDR_W'(`CDM_INTEN_OFS)) begin
                  prdata_next[`CDM_ST_TXC_BIT] = txc_en_reg;
               end else if (ofs == ADDR_W'(`CDM_LERR_OFS)) begin
                  prdata_next[2:0] = lec_reg;
               end else if (ofs == ADDR_W'(`CDM_TSCTRL_OFS)) begin
                  prdata_next[`CDM_TS_EN_BIT]   = ts_en_reg;
                  prdata_next[`CDM_TS_SEL_BIT]  = ts_sel_reg;
                  prdata_next[`CDM_TS_LOCK_BIT] = ts_lock_reg;
                  prdata_next[`CDM_TS_OUT_BIT]  = timestamp_toggle_out;
               end else if (ofs == ADDR_W'(`CDM_TXREQ_OFS)) begin
                  prdata_next[`CDM_TXREQ_BIT] = tx_request_bit;
               end else begin
                  hit = 1'b0;
               end
               pslverr_next = !hit;
            end
         end
         cdm_pkg::CDM_APB_ACCESS: begin
            apb_state_next = cdm_pkg::CDM_APB_IDLE;
            prdata_next    = prdata;
            pslverr_next   = 1'b0;
         end
         default: apb_state_next = cdm_pkg::CDM_APB_IDLE;
      endcase
   end

   // software writes and hardware events; hardware set wins over write-1 clear
   always_comb begin
      mode_next    = mode_reg;
      al_next      = al_reg;
      valid_next   = valid_reg;
      ps0_next     = ps0_reg;
      wake_next    = wake_reg;
      intst_next   = intst_reg;
      txc_en_next  = txc_en_reg;
      lec_next     = lec_reg;
      ts_en_next   = ts_en_reg;
      ts_sel_next  = ts_sel_reg;
      ts_lock_next = ts_lock_reg;
      txreq_next   = tx_request_bit;
      sw_txreq_set = 1'b0;
      if (wr_access) begin
         if (ofs == ADDR_W'(`CDM_CTRL_OFS)) begin
            mode_next = pwdata[`CDM_CTRL_MODE_MSB:`CDM_CTRL_MODE_LSB];
            al_next   = pwdata[`CDM_CTRL_AL_BIT];
            ps0_next  = pwdata[`CDM_CTRL_PS0_BIT];
            if (pwdata[`CDM_CTRL_VALID_BIT]) begin
               valid_next = 1'b0;
            end
            if (pwdata[`CDM_CTRL_WAKE_BIT]) begin
               wake_next = 1'b0;
            end
         end else if (ofs == ADDR_W'(`CDM_INTST_OFS)) begin
            intst_next = intst_reg & ~pwdata[4:0];
         end else if (ofs == ADDR_W'(`CDM_INTEN_OFS)) begin
            txc_en_next = pwdata[`CDM_ST_TXC_BIT];
         end else if (ofs == ADDR_W'(`CDM_TSCTRL_OFS)) begin
            ts_en_next   = pwdata[`CDM_TS_EN_BIT];
            ts_sel_next  = pwdata[`CDM_TS_SEL_BIT];
            ts_lock_next = pwdata[`CDM_TS_LOCK_BIT];
         end else if (ofs == ADDR_W'(`CDM_TXREQ_OFS)) begin
            sw_txreq_set = pwdata[`CDM_TXREQ_BIT];
         end
      end
      // completion drops the request unless software sets it in the same cycle; aborts drop it when no retry is allowed
      if (core_tx_success) begin
         txreq_next = 1'b0;
      end
      if (core_arb_loss && !cur_perm.retry_arb) begin
         txreq_next = 1'b0;
      end
      if (core_tx_error && !cur_perm.retry_err) begin
         txreq_next = 1'b0;
      end
      if (sw_txreq_set) begin
         txreq_next = 1'b1;
      end
      if (core_tx_success) begin
         intst_next[`CDM_ST_TXC_BIT] = 1'b1;
      end
      if (core_arb_loss) begin
         intst_next[`CDM_ST_ARBL_BIT] = 1'b1;
      end
      if (core_tx_error) begin
         intst_next[`CDM_ST_PERR_BIT] = 1'b1;
         lec_next = core_error_code;
      end
      if (core_rx_valid && mode_reg != `CDM_MODE_INIT) begin
         valid_next = 1'b1;
      end
      // wake on recessive-to-dominant while asleep; software clears the sleep bit
      if (ps0_reg && rx_sync_reg[2] && !rx_sync_reg[1]) begin
         wake_next = 1'b1;
      end
      if (lock_stop) begin
         ts_en_next = 1'b0;
      end
   end

   // time stamp: event select, enable gating and the buffer-0 lock
   always_comb begin
      ts_event  = core_data_frame && (ts_sel_reg ? core_eof : core_sof);
      lock_stop = ts_lock_reg && core_store_start && !core_store_remote
                  && core_store_buf == BUF_W'(`CDM_BUF0);
      ts_out_next = timestamp_toggle_out;
      if (ts_en_reg && ts_event) begin
         ts_out_next = !timestamp_toggle_out;
      end
   end

   // pins and mode permissions
   always_comb begin
      perm_next = cur_perm;
      irq_next  = intst_next[`CDM_ST_TXC_BIT] && txc_en_next;
      if (perm_next.drive_pin) begin
         tx_pin_next = core_tx_bit;
      end else begin
         tx_pin_next = `CDM_RECESSIVE;
      end
      if (perm_next.loopback) begin
         core_rx_next = core_tx_bit;
      end else begin
         core_rx_next = rx_sync_reg[1];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_state_reg        <= cdm_pkg::CDM_APB_IDLE;
         prdata               <= 32'h0000_0000;
         pready               <= 1'b0;
         pslverr              <= 1'b0;
         mode_reg             <= `CDM_MODE_INIT;
         al_reg               <= 1'b0;
         valid_reg            <= 1'b0;
         ps0_reg              <= 1'b0;
         wake_reg             <= 1'b0;
         intst_reg            <= 5'h00;
         txc_en_reg           <= 1'b0;
         lec_reg              <= 3'h0;
         ts_en_reg            <= 1'b0;
         ts_sel_reg           <= 1'b0;
         ts_lock_reg          <= 1'b0;
         timestamp_toggle_out <= 1'b0;
         tx_request_bit       <= 1'b0;
         tx_complete_irq      <= 1'b0;
         perm_reg             <= '0;
         rx_sync_reg          <= 3'h7;
         bus_tx_pin           <= `CDM_RECESSIVE;
         core_rx_bit          <= `CDM_RECESSIVE;
      end else begin
         apb_state_reg        <= apb_state_next;
         prdata               <= prdata_next;
         pready               <= pready_next;
         pslverr              <= pslverr_next;
         mode_reg             <= mode_next;
         al_reg               <= al_next;
         valid_reg            <= valid_next;
         ps0_reg              <= ps0_next;
         wake_reg             <= wake_next;
         intst_reg            <= intst_next;
         txc_en_reg           <= txc_en_next;
         lec_reg              <= lec_next;
         ts_en_reg            <= ts_en_next;
         ts_sel_reg           <= ts_sel_next;
         ts_lock_reg          <= ts_lock_next;
         timestamp_toggle_out <= ts_out_next;
         tx_request_bit       <= txreq_next;
         tx_complete_irq      <= irq_next;
         perm_reg             <= perm_next;
         rx_sync_reg          <= {rx_sync_reg[1:0], bus_rx_pin};
         bus_tx_pin           <= tx_pin_next;
         core_rx_bit          <= core_rx_next;
      end
   end

   assign tx_enable       = perm_reg.tx;
   assign ack_enable      = perm_reg.ack;
   assign errframe_enable = perm_reg.errframe;
   assign retry_arb_en    = perm_reg.retry_arb;
   assign retry_err_en    = perm_reg.retry_err;
   assign block_tx_en     = perm_reg.block_tx;
   assign store_enable    = perm_reg.store;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_selftest_held;
      (mode_reg == `CDM_MODE_SELFTEST) [*2];
   endsequence

   property p_single_err_drop;
      (mode_reg == `CDM_MODE_SINGLE && core_tx_error && !sw_txreq_set) |=> !tx_request_bit;
   endproperty
   a_single_err_drop: assert property (p_single_err_drop) else $error("request kept after error");

   property p_single_al_retry;
      (mode_reg == `CDM_MODE_SINGLE && al_reg && core_arb_loss && tx_request_bit
       && !core_tx_error && !core_tx_success) |=> tx_request_bit;
   endproperty
   a_single_al_retry: assert property (p_single_al_retry) else $error("retry lost on loss");

   property p_al_ignored;
      (mode_reg == `CDM_MODE_NORMAL) |=> (retry_arb_en && retry_err_en);
   endproperty
   a_al_ignored: assert property (p_al_ignored) else $error("normal mode retry off");

   property p_arb_flag;
      core_arb_loss |=> intst_reg[`CDM_ST_ARBL_BIT];
   endproperty
   a_arb_flag: assert property (p_arb_flag) else $error("loss flag not set");

   property p_txc_irq;
      (core_tx_success && txc_en_reg && !wr_access) |=> tx_complete_irq;
   endproperty
   a_txc_irq: assert property (p_txc_irq) else $error("completion irq missing");

   property p_selftest_pin;
      s_selftest_held |-> (bus_tx_pin == `CDM_RECESSIVE && core_rx_bit == $past(core_tx_bit));
   endproperty
   a_selftest_pin: assert property (p_selftest_pin) else $error("self-test not isolated");

   property p_ts_toggle;
      (ts_en_reg && ts_event) |=> (timestamp_toggle_out != $past(timestamp_toggle_out));
   endproperty
   a_ts_toggle: assert property (p_ts_toggle) else $error("time-stamp did not toggle");

   property p_ts_still;
      !ts_en_reg |=> $stable(timestamp_toggle_out);
   endproperty
   a_ts_still: assert property (p_ts_still) else $error("time-stamp moved while off");

   property p_ts_lock;
      lock_stop |=> !ts_en_reg;
   endproperty
   a_ts_lock: assert property (p_ts_lock) else $error("lock did not clear enable");

   property p_valid_set;
      (core_rx_valid && mode_reg != `CDM_MODE_INIT) |=> valid_reg;
   endproperty
   a_valid_set: assert property (p_valid_set) else $error("valid flag not set");

endmodule : cdm_can_diag
`default_nettype wire

// ==== verification/cdm_bus_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdm_bus_partner (
   input  wire logic        pclk,
   input  wire logic        tx_pin,
   input  wire logic        remote_dom,
   input  wire logic        ts_in,
   output logic             rx_pin,
   output logic [15:0]      cap_count
);
   logic        ts_d    = 1'b0;
   logic [15:0] cap_cnt = 16'h0;
   // wired-and bus, recessive by pull-up
   assign rx_pin    = tx_pin & ~remote_dom;
   assign cap_count = cap_cnt;
   // capture timer counts both edges of the time-stamp line
   always @(posedge pclk) begin
      ts_d <= ts_in;
      if (ts_d !== ts_in) cap_cnt <= cap_cnt + 16'h1;
   end
endmodule : cdm_bus_partner
`default_nettype wire

// ==== verification/can_diag_modes_timestamp_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cdm_defs.svh"
module can_diag_modes_timestamp_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h23d0d792;
   logic pready, pslverr, bus_rx, bus_tx, core_tx_bit = 0, core_rx_bit, rnd_bit = 0;
   logic [6:0]  pulses = 7'h00;
   logic [2:0]  ecode = 3'h0, rxh = 3'h7;
   logic [3:0]  sbuf = 4'h0;
   logic data_fr = 1, remote = 0, rnd_remote = 0, wake_dom = 0, remote_dom, prev_tx = 0;
   logic req, txe, acke, erre, rae, ree, blke, ste, irq, ts_out;
   logic [15:0] cap_count;
   int mismatches = 0, num_checks = 0, pin_mode = 0, ts_cnt = 0;
   always #2 pclk = ~pclk;
   assign remote_dom = rnd_remote ? rnd_bit : wake_dom;
   cdm_can_diag u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_rx_pin(bus_rx), .bus_tx_pin(bus_tx), .core_tx_bit(core_tx_bit),
      .core_rx_bit(core_rx_bit), .core_tx_success(pulses[0]), .core_arb_loss(pulses[1]),
      .core_tx_error(pulses[2]), .core_error_code(ecode), .core_rx_valid(pulses[3]),
      .core_sof(pulses[4]), .core_eof(pulses[5]), .core_data_frame(data_fr),
      .core_store_start(pulses[6]), .core_store_buf(sbuf), .core_store_remote(remote),
      .tx_request_bit(req), .tx_enable(txe), .ack_enable(acke), .errframe_enable(erre),
      .retry_arb_en(rae), .retry_err_en(ree), .block_tx_en(blke), .store_enable(ste),
      .tx_complete_irq(irq), .timestamp_toggle_out(ts_out));
   cdm_bus_partner u_partner (.pclk(pclk), .tx_pin(bus_tx), .remote_dom(remote_dom),
      .ts_in(ts_out), .rx_pin(bus_rx), .cap_count(cap_count));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // permission vector: tx, ack, error frame, retry arb, retry err, block, store
   function automatic logic [6:0] perm(input int m, input logic al);
      case (m)
         1, 5: return 7'h7d;
         2: return 7'h7f;
         3: return 7'h01;
         4: return {3'h7, al, 3'h1};
         default: return 7'h00;
      endcase
   endfunction : perm
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, r, exp);
   endtask : rchk
   task automatic pulse(input logic [6:0] m);
      pulses <= m;
      @(posedge pclk);
      pulses <= 7'h00;
      repeat (2) @(posedge pclk);
   endtask : pulse
   task automatic tse(input logic [6:0] m, input logic tog);
      pulse(m);
      if (tog) ts_cnt++;
      chk("ts_out", ts_out, ts_cnt % 2);
      chk("capture", cap_count, ts_cnt);
   endtask : tse
   always @(posedge pclk) begin
      seed <= lfsr(seed);
      core_tx_bit <= seed[0];
      rnd_bit <= seed[5];
      if (pin_mode == 2) chk("loopback", core_rx_bit, prev_tx);
      if (pin_mode == 2) chk("tx_pin_st", bus_tx, 1);
      if (pin_mode == 1) chk("tx_pin", bus_tx, prev_tx);
      if (pin_mode == 1) chk("rx_path", core_rx_bit, rxh[2]);
      prev_tx <= core_tx_bit;
      rxh <= {rxh[1:0], bus_rx};
   end
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      final_report();
   end
   initial begin
      logic [31:0] r;
      logic e;
      logic [2:0] c;
      repeat (12) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk("ts_rst", ts_out, 0);
      chk("tx_rst", bus_tx, 1);
      for (int a = 0; a < 24; a += 4) rchk(a[7:0], 32'h0, "reset");
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk("slverr", e, 1);
      for (int al = 0; al < 2; al++)
         for (int m = 0; m < 6; m++) begin
            wr(`CDM_CTRL_OFS, m | (al << 4));
            @(posedge pclk);
            chk("perm", {txe, acke, erre, rae, ree, blke, ste}, perm(m, al[0]));
         end
      wr(`CDM_CTRL_OFS, 32'h4);
      wr(`CDM_TXREQ_OFS, 1);
      pulse(7'h02);
      rchk(`CDM_TXREQ_OFS, 0, "req_arb");
      wr(`CDM_TXREQ_OFS, 1);
      c = seed[10:8];
      ecode <= c;
      pulse(7'h04);
      rchk(`CDM_TXREQ_OFS, 0, "req_err");
      rchk(`CDM_INTST_OFS, 32'h18, "abort_flags");
      rchk(`CDM_LERR_OFS, c, "err_code");
      wr(`CDM_INTST_OFS, 32'h18);
      wr(`CDM_TXREQ_OFS, 1);
      pulse(7'h01);
      rchk(`CDM_TXREQ_OFS, 0, "req_ok");
      chk("req_out", req, 0);
      rchk(`CDM_INTST_OFS, 1, "txc");
      chk("irq_off", irq, 0);
      wr(`CDM_INTEN_OFS, 1);
      chk("irq_on", irq, 1);
      wr(`CDM_INTST_OFS, 1);
      chk("irq_clr", irq, 0);
      for (int m = 1; m < 5; m += 3) begin
         wr(`CDM_CTRL_OFS, m | 32'h10);
         wr(`CDM_TXREQ_OFS, 1);
         pulse(7'h02);
         rchk(`CDM_TXREQ_OFS, 1, "retry_arb");
         chk("req_hold", req, 1);
         pulse(7'h04);
         rchk(`CDM_TXREQ_OFS, m == 1, "retry_err");
         pulse(7'h01);
      end
      for (int m = 1; m < 3; m++) begin
         wr(`CDM_CTRL_OFS, m == 1 ? 1 : 5);
         rnd_remote <= 1;
         repeat (4) @(posedge pclk);
         pin_mode <= m;
         repeat (40) @(posedge pclk);
         pin_mode <= 0;
         rnd_remote <= 0;
      end
      wr(`CDM_CTRL_OFS, 32'h1005);
      wake_dom <= 1;
      repeat (8) @(posedge pclk);
      wake_dom <= 0;
      rchk(`CDM_CTRL_OFS, 32'h3005, "wake");
      wr(`CDM_CTRL_OFS, 32'h2005);
      rchk(`CDM_CTRL_OFS, 32'h5, "wake_clr");
      wr(`CDM_CTRL_OFS, 0);
      pulse(7'h08);
      rchk(`CDM_CTRL_OFS, 0, "valid_init");
      wr(`CDM_CTRL_OFS, 3);
      pulse(7'h08);
      rchk(`CDM_CTRL_OFS, 32'h103, "valid_rx");
      wr(`CDM_CTRL_OFS, 32'h101);
      wr(`CDM_TSCTRL_OFS, 1);
      tse(7'h10, 1);
      tse(7'h20, 0);
      wr(`CDM_TSCTRL_OFS, 3);
      tse(7'h20, 1);
      tse(7'h10, 0);
      data_fr <= 0;
      tse(7'h20, 0);
      data_fr <= 1;
      wr(`CDM_TSCTRL_OFS, 2);
      tse(7'h20, 0);
      wr(`CDM_TSCTRL_OFS, 7);
      sbuf <= 4'h1;
      tse(7'h40, 0);
      sbuf <= 4'h0;
      remote <= 1;
      tse(7'h40, 0);
      remote <= 0;
      rchk(`CDM_TSCTRL_OFS, 7, "lock_run");
      tse(7'h60, 1);
      rchk(`CDM_TSCTRL_OFS, 32'h6 | ((ts_cnt % 2) << 8), "lock_stop");
      tse(7'h20, 0);
      final_report();
   end
endmodule : can_diag_modes_timestamp_tb_top
`default_nettype wire
